// ### logic/laa_defs.svh
// constants for the locality access arbiter
`ifndef LAA_DEFS_SVH
`define LAA_DEFS_SVH
`define LAA_NUM_LOC 5
`define LAA_BIT_VALID 7
`define LAA_BIT_ACTIVE 5
`define LAA_BIT_SEIZED 4
`define LAA_BIT_SEIZE 3
`define LAA_BIT_PENDING 2
`define LAA_BIT_REQUEST 1
`define LAA_BIT_ESTAB 0
`define LAA_SHUTDOWN_READ 8'hFF
`define LAA_IN_BUF_BYTES 16'h0300
`define LAA_NUM_TESTS 3'h7
`define LAA_TEST_REMAINING 3'h7
`define LAA_CONT_TEST_MS 1000
`define LAA_CLK_MHZ 100
`endif

// ### logic/laa_pkg.sv
// types for the locality access arbiter
package laa_pkg;
	typedef enum logic [6:0] {
		LAA_ST_RESET = 7'h01,
		LAA_ST_NVLOAD = 7'h02,
		LAA_ST_TEST = 7'h04,
		LAA_ST_READY = 7'h08,
		LAA_ST_CONT = 7'h10,
		LAA_ST_ERROR = 7'h20,
		LAA_ST_DEAD = 7'h40
	} laa_state_e;
	typedef logic [4:0] laa_loc_t;
endpackage : laa_pkg

// ### logic/laa_top.sv
// locality access register, ownership arbitration, self-test and error gating
`timescale 1ns/1ns
`include "laa_defs.svh"
//
// Function
// (RULE1) software writes one bit unless taking over
// (RULE2) multi-bit non-takeover write is discarded whole
// (RULE3) zero bits in a write change nothing
// (RULE4) bit 7 reads one only when valid
// (RULE5) valid stays zero until init completes
// (RULE6) software ignores bits while valid is zero
// (RULE7) never-valid device is treated as failed
// (RULE8) self-test hash, extend, startup, continue functions
// (RULE9) timeout capability query starts no self-test
// (RULE10) continue-selftest finishes within one second
// (RULE11) command input of 768 bytes accepted
// (RULE12) no good response after known error
// (RULE13) error goes to shutdown or error mode
// (RULE14) error mode keeps registers working, responses failing
// (RULE15) shutdown ignores access, reads return FFh
// (RULE16) software bounds its retries, then times out
// (RULE17) software requests via its own locality address
// (RULE18) request granted at once when unowned
// (RULE19) release grants highest pending, else none
// (RULE20) higher locality may take over ownership
// (RULE21) takeover from equal or lower is ignored
// (RULE22) active bit write clears active and request
module laa_top import laa_pkg::*; #(
	parameter int unsigned CONT_LIMIT = `LAA_CONT_TEST_MS * 1000 * `LAA_CLK_MHZ - 1
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [2:0] loc_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic nv_estab_i,
	output logic [2:0] bist_sel_o,
	output logic bist_req_o,
	input wire logic bist_done_i,
	input wire logic bist_pass_i,
	input wire logic cont_selftest_i,
	input wire logic cap_timeout_query_i,
	output logic cap_ack_o,
	output logic cmd_accept_o,
	output logic [15:0] in_buf_size_o,
	input wire logic error_i,
	input wire logic attack_i,
	input wire logic resp_valid_i,
	input wire logic resp_ok_i,
	input wire logic [7:0] resp_data_i,
	output logic resp_valid_o,
	output logic resp_ok_o,
	output logic [7:0] resp_data_o,
	output logic [4:0] owner_o,
	output logic error_mode_o
);
	// ************************************************************
	// reset and pin synchronisers
	// ************************************************************
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [1:0] estab_sync_r;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			estab_sync_r <= 2'h0;
		end else if (ce_i) begin
			estab_sync_r <= {estab_sync_r[0], nv_estab_i};
		end
	end

	// ************************************************************
	// self-test and error sequencer
	// ************************************************************
	laa_state_e state_r;
	logic [2:0] step_r;
	logic [31:0] cont_cnt_r;
	logic estab_r;
	logic regs_live;
	logic dead;
	assign dead = (state_r == LAA_ST_DEAD);
	// error mode still serves registers, the sequencer states before ready and the dead state hold them off
	assign regs_live = (state_r == LAA_ST_READY) || (state_r == LAA_ST_CONT) || (state_r == LAA_ST_ERROR);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= LAA_ST_RESET;
			step_r <= 3'h0;
			cont_cnt_r <= 32'h0;
		end else if (ce_i) begin
			if (attack_i) begin
				state_r <= LAA_ST_DEAD; // see (RULE13)
			end else begin
				case (state_r)
					LAA_ST_RESET: state_r <= LAA_ST_NVLOAD;
					LAA_ST_NVLOAD: begin
						state_r <= LAA_ST_TEST;
						step_r <= 3'h0;
					end
					LAA_ST_TEST: begin
						if (error_i || (bist_done_i && !bist_pass_i)) begin
							state_r <= LAA_ST_ERROR; // see (RULE13)
						end else if (bist_done_i) begin
							// one pass per boot-critical function, in order
							if (step_r == `LAA_NUM_TESTS - 3'h1) begin
								state_r <= LAA_ST_READY; // see (RULE8)
							end
							step_r <= step_r + 3'h1;
						end
					end
					LAA_ST_READY: begin
						if (error_i) begin
							state_r <= LAA_ST_ERROR;
						end else if (cont_selftest_i) begin
							state_r <= LAA_ST_CONT;
							cont_cnt_r <= 32'h0;
						end
					end
					LAA_ST_CONT: begin
						// an overrun is treated as a failed test, not a silent pass
						if (error_i || (bist_done_i && !bist_pass_i) || cont_cnt_r == CONT_LIMIT) begin
							state_r <= LAA_ST_ERROR; // see (RULE10)
						end else if (bist_done_i) begin
							state_r <= LAA_ST_READY;
						end
						cont_cnt_r <= cont_cnt_r + 32'h1;
					end
					LAA_ST_ERROR: state_r <= LAA_ST_ERROR;
					LAA_ST_DEAD: state_r <= LAA_ST_DEAD;
					default: state_r <= LAA_ST_ERROR;
				endcase
			end
		end
	end

	// establishment bit reads zero until the stored value has been fetched
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			estab_r <= 1'b0;
		end else if (ce_i && (state_r == LAA_ST_NVLOAD || state_r == LAA_ST_TEST)) begin
			// the synchroniser is still filling at the first load edge, so keep loading until ready
			estab_r <= estab_sync_r[1]; // see (RULE5)
		end
	end

	assign bist_req_o = (state_r == LAA_ST_TEST) || (state_r == LAA_ST_CONT);
	assign bist_sel_o = (state_r == LAA_ST_CONT) ? `LAA_TEST_REMAINING : step_r;
	assign cmd_accept_o = (state_r == LAA_ST_READY) || (state_r == LAA_ST_ERROR);
	assign in_buf_size_o = `LAA_IN_BUF_BYTES; // see (RULE11)
	assign error_mode_o = (state_r == LAA_ST_ERROR);

	// the query is served from fixed values, the sequencer never sees it
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cap_ack_o <= 1'b0;
		end else if (ce_i) begin
			cap_ack_o <= cap_timeout_query_i && cmd_accept_o; // see (RULE9)
		end
	end

	// ************************************************************
	// response gating
	// ************************************************************
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			resp_valid_o <= 1'b0;
			resp_ok_o <= 1'b0;
			resp_data_o <= 8'h00;
		end else if (ce_i) begin
			resp_valid_o <= resp_valid_i && !dead; // see (RULE15)
			resp_ok_o <= resp_valid_i && resp_ok_i && state_r == LAA_ST_READY && !error_i; // see (RULE12)
			// payload is zeroed outside the working state so no secret leaks with an error code
			resp_data_o <= (state_r == LAA_ST_READY && !error_i) ? resp_data_i : 8'h00; // see (RULE14)
		end
	end

	// ************************************************************
	// locality arbitration
	// ************************************************************
	laa_loc_t active_r;
	laa_loc_t req_r;
	laa_loc_t seized_r;
	laa_loc_t me;
	logic wr_ok;
	logic one_hot;
	logic seize_ok;
	logic [2:0] act_idx;

	function automatic laa_loc_t hi_pick(input laa_loc_t v);
		laa_loc_t r;
		r = 5'h00;
		for (int i = 0; i < `LAA_NUM_LOC; i++) begin
			if (v[i]) begin
				r = 5'h01 << i;
			end
		end
		return r;
	endfunction : hi_pick

	always_comb begin
		act_idx = 3'h0;
		for (int i = 0; i < `LAA_NUM_LOC; i++) begin
			if (active_r[i]) begin
				act_idx = 3'(i);
			end
		end
	end

	assign me = (loc_i < 3'(`LAA_NUM_LOC)) ? (5'h01 << loc_i) : 5'h00;
	assign wr_ok = ce_i && wr_i && regs_live && |me;
	assign one_hot = ($countones(wdata_i) == 1); // see (RULE2)
	assign seize_ok = wdata_i[`LAA_BIT_SEIZE] && loc_i != 3'h0 && (active_r == 5'h00 || loc_i > act_idx); // see (RULE21)

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			active_r <= 5'h00;
			req_r <= 5'h00;
			seized_r <= 5'h00;
		end else if (wr_ok) begin
			if (wdata_i[`LAA_BIT_SEIZE]) begin
				if (seize_ok) begin
					active_r <= me; // see (RULE20)
					req_r <= req_r & ~me;
					seized_r <= (seized_r | active_r) & ~(wdata_i[`LAA_BIT_SEIZED] ? me : 5'h00);
				end
			end else if (one_hot) begin
				if (wdata_i[`LAA_BIT_ACTIVE]) begin
					if ((active_r & me) != 5'h00) begin
						active_r <= hi_pick(req_r & ~me); // see (RULE19)
						req_r <= req_r & ~me & ~hi_pick(req_r & ~me);
					end else begin
						req_r <= req_r & ~me; // see (RULE22)
					end
				end else if (wdata_i[`LAA_BIT_SEIZED]) begin
					seized_r <= seized_r & ~me;
				end else if (wdata_i[`LAA_BIT_REQUEST]) begin
					if (active_r == 5'h00) begin
						active_r <= me; // see (RULE18)
					end else if ((active_r & me) == 5'h00) begin
						req_r <= req_r | me; // see (RULE17)
					end
				end
			end
		end
	end
	assign owner_o = active_r;

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 8'h00;
		end else if (ce_i && rd_i) begin
			if (dead) begin
				rdata_o <= `LAA_SHUTDOWN_READ; // see (RULE15)
			end else begin
				rdata_o <= {regs_live, 1'b0, |(active_r & me), |(seized_r & me), 1'b0,
					|(req_r & ~me), |(req_r & me), estab_r}; // see (RULE4)
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	chk_valid_before_init: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE5)
		(ce_i && rd_i && !dead && !regs_live) |=> rdata_o[7] == 1'b0) else $error("valid bit set before init");
	chk_shutdown_read_ff: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE15)
		(ce_i && rd_i && dead) |=> rdata_o == 8'hFF) else $error("shutdown read not FFh");
	chk_multibit_ignored: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE2)
		(wr_ok && !wdata_i[3] && $countones(wdata_i) > 1) |=> $stable(active_r) && $stable(req_r) && $stable(seized_r))
		else $error("multi-bit write took effect");
	chk_idle_grant: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE18)
		(wr_ok && wdata_i == 8'h02 && active_r == 5'h00) |=> active_r == $past(me)) else $error("idle request not granted");
	chk_release_none: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE19)
		(wr_ok && wdata_i == 8'h20 && (active_r & me) != 5'h00 && req_r == 5'h00) |=> active_r == 5'h00)
		else $error("release left an owner");
	chk_takeover_ignored: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE21)
		(wr_ok && wdata_i[3] && active_r != 5'h00 && loc_i <= act_idx) |=> $stable(active_r))
		else $error("low takeover took effect");
	chk_takeover_wins: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE20)
		(wr_ok && wdata_i[3] && loc_i != 3'h0 && active_r != 5'h00 && loc_i > act_idx) |=> active_r == $past(me))
		else $error("takeover failed");
	chk_release_clears: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE22)
		(wr_ok && wdata_i == 8'h20) |=> (req_r & $past(me)) == 5'h00) else $error("release kept request");
	chk_no_good_resp: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE12)
		(ce_i && state_r != LAA_ST_READY) |=> !resp_ok_o) else $error("good response outside ready");
	chk_query_no_test: assert property (@(posedge clk_i) disable iff (!rst_n) // see (RULE9)
		(ce_i && cap_timeout_query_i && state_r == LAA_ST_READY && !cont_selftest_i && !error_i && !attack_i)
		|=> state_r == LAA_ST_READY) else $error("query started a test");
endmodule : laa_top

// ### tb/laa_bist_model.sv
// self-test engine model that answers the block's test requests
`timescale 1ns/1ns
module laa_bist_model (
	input wire logic clk_i,
	input wire logic bist_req_i,
	input wire logic pass_i,
	output logic done_o,
	output logic pass_o
);
	logic [1:0] cnt_r;
	// ****************************************
	// answer each request after four cycles
	// ****************************************
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		if (!bist_req_i || done_o) begin
			cnt_r <= 2'h0;
		end else if (cnt_r == 2'h3) begin
			cnt_r <= 2'h0;
			done_o <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 2'h1;
		end
	end
	// the result means nothing outside the done pulse, so it shows the opposite there
	assign pass_o = done_o ? pass_i : ~pass_i;
endmodule : laa_bist_model

// ### tb/locality_access_arbiter_bench.sv
// bench for the locality access arbiter
`timescale 1ns/1ns
module locality_access_arbiter_bench;
	logic clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic cont_i = 1'b0;
	logic capq_i = 1'b0;
	logic err_i = 1'b0;
	logic atk_i = 1'b0;
	logic rv_i = 1'b0;
	logic rok_i = 1'b0;
	logic tpass = 1'b1;
	logic [2:0] loc_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdat_i = 8'h00;
	logic [7:0] rdata_o, resp_data_o, rd_v;
	logic [2:0] bist_sel_o;
	logic [15:0] in_buf_size_o;
	logic [4:0] owner_o;
	logic bist_req_o, bist_done, bist_pass, cap_ack_o, cmd_accept_o, resp_valid_o, resp_ok_o, error_mode_o;
	int n_fail = 0;
	int checks_done = 0;
	always #5 clk_i = ~clk_i;
	laa_top #(.CONT_LIMIT(50)) i_dut (.clk_i, .resetn_i, .ce_i(1'b1), .wr_i, .rd_i, .loc_i, .wdata_i, .rdata_o,
		.nv_estab_i(1'b1), .bist_sel_o, .bist_req_o, .bist_done_i(bist_done), .bist_pass_i(bist_pass),
		.cont_selftest_i(cont_i), .cap_timeout_query_i(capq_i), .cap_ack_o, .cmd_accept_o, .in_buf_size_o,
		.error_i(err_i), .attack_i(atk_i), .resp_valid_i(rv_i), .resp_ok_i(rok_i), .resp_data_i(rdat_i),
		.resp_valid_o, .resp_ok_o, .resp_data_o, .owner_o, .error_mode_o);
	laa_bist_model i_bist (.clk_i, .bist_req_i(bist_req_o), .pass_i(tpass), .done_o(bist_done), .pass_o(bist_pass));
	// ****************************************
	// access tasks
	// ****************************************
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one set bit per write except takeover writes is the caller's duty
	task automatic wr(input logic [2:0] l, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		loc_i <= l;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		wdata_i <= ~d;
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] l);
		@(posedge clk_i);
		rd_i <= 1'b1;
		loc_i <= l;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(posedge clk_i);
		#1;
		rd_v = rdata_o;
	endtask : rd
	task automatic pulse(input logic [4:0] m);
		@(posedge clk_i);
		{atk_i, err_i, capq_i, cont_i, rv_i} <= m;
		@(posedge clk_i);
		{atk_i, err_i, capq_i, cont_i, rv_i} <= 5'h00;
		#1;
	endtask : pulse
	// a device that never shows valid is given up on
	task automatic wait_ready;
		int i;
		for (i = 0; i < 40; i++) begin
			rd(3'h0);
			if (rd_v[7] === 1'b1) begin
				break;
			end
		end
		if (i == 40) begin
			n_fail++;
			results();
		end
	endtask : wait_ready
	task automatic wait_idle;
		int i;
		repeat (2) @(posedge clk_i);
		for (i = 0; i < 100 && bist_req_o !== 1'b0; i++) begin
			@(posedge clk_i);
		end
		#1;
		if (i == 100) begin
			n_fail++;
			results();
		end
	endtask : wait_idle
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(3'h0);
		chk("early valid", rd_v[7], 1'b0);
		wr(3'h1, 8'h02);
		wait_ready();
		chk("ready view", rd_v, 8'h81);
		chk("early write", owner_o, 5'h00);
		chk("buffer size", in_buf_size_o, 16'h0300);
		$display("test boot done");
		wr(3'h2, 8'h02);
		chk("grant idle", owner_o, 5'h04);
		wr(3'h1, 8'h02);
		wr(3'h3, 8'h02);
		wr(3'h2, 8'h22);
		wr(3'h2, 8'h00);
		chk("held owner", owner_o, 5'h04);
		rd(3'h2);
		chk("owner view", rd_v, 8'hA5);
		wr(3'h2, 8'h20);
		chk("release top", owner_o, 5'h08);
		wr(3'h3, 8'h20);
		chk("release next", owner_o, 5'h02);
		rd(3'h1);
		chk("granted view", rd_v, 8'hA1);
		wr(3'h0, 8'h08);
		wr(3'h1, 8'h08);
		chk("low takeover", owner_o, 5'h02);
		wr(3'h4, 8'h08);
		chk("takeover", owner_o, 5'h10);
		rd(3'h1);
		chk("taken view", rd_v, 8'h91);
		wr(3'h1, 8'h02);
		wr(3'h1, 8'h20);
		wr(3'h4, 8'h20);
		chk("release all", owner_o, 5'h00);
		$display("test ownership done");
		pulse(5'h04);
		chk("cap ack", {cap_ack_o, bist_req_o}, 2'h2);
		pulse(5'h02);
		@(posedge clk_i);
		#1;
		chk("cont test", {bist_req_o, bist_sel_o}, 4'hF);
		wait_idle();
		chk("cont ok", {cmd_accept_o, error_mode_o}, 2'h2);
		rdat_i <= 8'h5A;
		rok_i <= 1'b1;
		pulse(5'h01);
		chk("resp good", {resp_valid_o, resp_ok_o, resp_data_o}, 10'h35A);
		$display("test selftest done");
		pulse(5'h08);
		chk("error mode", error_mode_o, 1'b1);
		pulse(5'h01);
		chk("resp error", {resp_valid_o, resp_ok_o, resp_data_o}, 10'h200);
		wr(3'h2, 8'h02);
		chk("err regs", owner_o, 5'h04);
		pulse(5'h10);
		rd(3'h2);
		chk("dead read", rd_v, 8'hFF);
		wr(3'h2, 8'h20);
		pulse(5'h01);
		chk("dead state", {owner_o, resp_valid_o}, 6'h08);
		$display("test errors done");
		resetn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		wait_ready();
		tpass <= 1'b0;
		pulse(5'h02);
		wait_idle();
		rd(3'h0);
		chk("cont fail", {error_mode_o, rd_v[7]}, 2'h3);
		$display("test reset done");
		results();
	end
endmodule : locality_access_arbiter_bench
